// ### logic/pprsc_pkg.sv
// Purpose: Shared constants for the power, reset and protection controller
// Assumes: 100 MHz system clock, AHB-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package pprsc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POWERUP_CLEAR_TIME_NS = 1000;
  localparam int unsigned POWERUP_CLEAR_CYC =
    (POWERUP_CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OUT_VALID_NS = 20;
  localparam int unsigned OUT_VALID_CYC = OUT_VALID_NS / CLK_PERIOD_NS;
  localparam int unsigned IN_VALID_NS = 5;
  localparam int unsigned IN_VALID_CYC =
    (IN_VALID_NS / CLK_PERIOD_NS) < 1 ? 1 : IN_VALID_NS / CLK_PERIOD_NS;
  localparam int unsigned NUM_CELLS = 8;

  localparam logic [7:0] ADDR_CONFIG    = 8'h00;
  localparam logic [7:0] ADDR_CELL_MODE = 8'h04;
  localparam logic [7:0] ADDR_PRELOAD   = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_SIG_LO    = 8'h10;
  localparam logic [7:0] ADDR_SIG_HI    = 8'h14;
  localparam logic [7:0] ADDR_VERIFY    = 8'h18;
  localparam logic [7:0] ADDR_FUSE      = 8'h1C;

  localparam int unsigned CFG_ARCH_LSB  = 0;
  localparam int unsigned CFG_SLEEP_EN  = 2;
  localparam logic [31:0] CONFIG_RESET  = 32'h0000_0000;
  localparam logic [15:0] CELL_MODE_RESET = 16'h0000;
  localparam int unsigned ST_HOLD      = 0;
  localparam int unsigned ST_CLEARING  = 1;
  localparam int unsigned ST_FUSE      = 2;
  localparam int unsigned ST_IN_BLOCK  = 3;

  typedef enum logic [1:0] {
    PPRSC_ARCH_REGISTERED = 2'b00,
    PPRSC_ARCH_COMPLEX    = 2'b01,
    PPRSC_ARCH_SIMPLE     = 2'b10
  } pprsc_arch_e;

  typedef enum logic [1:0] {
    PPRSC_CELL_REG_OUT  = 2'b00,
    PPRSC_CELL_COMB_IO  = 2'b01,
    PPRSC_CELL_COMB_OUT = 2'b10,
    PPRSC_CELL_INPUT    = 2'b11
  } pprsc_cell_e;

  typedef enum logic [1:0] {
    PPRSC_ST_CLEAR = 2'b00,
    PPRSC_ST_RUN   = 2'b01,
    PPRSC_ST_HOLD  = 2'b10,
    PPRSC_ST_WAKE  = 2'b11
  } pprsc_state_e;
endpackage

// ### logic/pprsc_sync.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module pprsc_sync
  import pprsc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pprsc_sync_s;

  pprsc_sync_s st;
  pprsc_sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;
endmodule // pprsc_sync

// ### logic/pprsc_ctrl.sv
// Purpose: Power-up clear, sleep hold, preload, protection and macrocell control
// Assumes: AHB-Lite slave, pins sampled through two flops, one clock
// Notes:   Pin clock and output enable are pins sampled like any input
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
// Functional notes
// R1: After power-up every macrocell register clears low so registered pins read high.
// R2: The system keeps the register clock source steady during the power-up clear time.
// R3: After the clear the system meets setup before the first rising register clock.
// R4: With sleep enabled the sleep pin high places the block in its hold state.
// R5: In hold all outputs and internal states are latched and kept; a preload write in hold still changes macro_q.
// R6: An output tri-stated when hold began stays tri-stated throughout hold.
// R7: In hold every input, clock and output-enable pin is ignored except the sleep pin.
// R8: With sleep disabled the sleep pin is an ordinary array input.
// R9: Each input and I/O pin keeps its last seen value when nobody drives it.
// R10: A programmer may force each macrocell register high or low.
// R11: Once the protection fuse is set, verify read-back and preload are refused.
// R12: A 64-bit user signature stays readable regardless of the fuse.
// R13: The programmer sets the protection fuse last since it acts at once.
// R14: Eight macrocells each act as registered out, comb I/O, comb out or input.
// R15: The block runs in exactly one of three architecture modes.
// R16: After sleep falls outputs are valid within 20 ns and inputs within 5 ns; the inputs here release after one 10 ns clock in wake.
// R17: In registered mode cells clock on the common clock pin and enable on the OE pin.
module pprsc_ctrl
  import pprsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        reg_clk_pin,
  input  wire logic        oe_n_pin,
  input  wire logic        sleep_hold_pin,
  input  wire logic [7:0]  in_pin,
  input  wire logic [7:0]  io_in,
  input  wire logic [7:0]  cell_d,
  output logic      [7:0]  io_out,
  output logic      [7:0]  io_oe,
  output logic      [8:0]  array_in,
  output logic             sleep_active
);
  typedef struct packed {
    pprsc_state_e state;
    logic [9:0]   cnt;
    logic [7:0]   macro_q;
    logic [7:0]   out_q;
    logic [7:0]   oe_q;
    logic [7:0]   in_keep;
    logic [7:0]   io_keep;
    logic         sleep_in_keep;
    logic         clk_prev;
    logic         in_block;
    logic [1:0]   arch;
    logic         sleep_en;
    logic [15:0]  cell_mode;
    logic [7:0]   comb_oe;
    logic [63:0]  signature;
    logic [31:0]  verify_word;
    logic         fuse;
    logic         ph_valid;
    logic         ph_write;
    logic [7:0]   ph_addr;
    logic [31:0]  rdata;
  } pprsc_ctrl_s;

  pprsc_ctrl_s st;
  pprsc_ctrl_s next_st;
  logic [7:0]  s_in;
  logic [7:0]  s_io;
  logic        s_clk;
  logic        s_oe_n;
  logic        s_sleep;

  pprsc_sync #(
    .W(19)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({reg_clk_pin, oe_n_pin, sleep_hold_pin, in_pin, io_in}),
    .dout   ({s_clk, s_oe_n, s_sleep, s_in, s_io})
  );

  function automatic pprsc_cell_e cell_of(input logic [15:0] m, input int unsigned i);
    cell_of = pprsc_cell_e'(m[2*i +: 2]);
  endfunction

  function automatic logic [31:0] cfg_word(input pprsc_ctrl_s s);
    cfg_word = 32'h0000_0000;
    cfg_word[CFG_ARCH_LSB +: 2] = s.arch;
    cfg_word[CFG_SLEEP_EN] = s.sleep_en;
  endfunction

  logic asleep;
  assign asleep = st.sleep_en && s_sleep; // R4 R8

  always_comb begin
    next_st = st;
    // Pin keepers: undriven pins read their last value
    if (!st.in_block) begin
      next_st.in_keep = s_in; // R9
      for (int i = 0; i < NUM_CELLS; i++) begin
        if (!st.oe_q[i]) begin
          next_st.io_keep[i] = s_io[i]; // R9
        end else begin
          next_st.io_keep[i] = st.out_q[i];
        end
      end
      next_st.clk_prev = s_clk;
    end
    if (!st.sleep_en) begin
      next_st.sleep_in_keep = s_sleep; // R8
    end

    case (st.state)
      PPRSC_ST_CLEAR: begin
        next_st.macro_q  = 8'h00; // R1
        next_st.out_q    = 8'hFF; // R1
        next_st.in_block = 1'b1;
        if (st.cnt >= 10'(POWERUP_CLEAR_CYC - 1)) begin
          next_st.state    = PPRSC_ST_RUN;
          next_st.cnt      = 10'h000;
          next_st.in_block = 1'b0;
        end else begin
          next_st.cnt = st.cnt + 10'h001;
        end
      end
      PPRSC_ST_RUN: begin
        if (asleep) begin
          next_st.state    = PPRSC_ST_HOLD; // R4
          next_st.in_block = 1'b1; // R7
        end else begin
          // Register update on rising edge of the sampled pin clock
          for (int i = 0; i < NUM_CELLS; i++) begin
            case (cell_of(st.cell_mode, i))
              PPRSC_CELL_REG_OUT: begin
                if (st.arch == PPRSC_ARCH_REGISTERED) begin
                  if (s_clk && !st.clk_prev) begin
                    next_st.macro_q[i] = cell_d[i]; // R17
                  end
                  next_st.out_q[i] = ~st.macro_q[i];
                  next_st.oe_q[i]  = ~s_oe_n; // R17
                end else begin
                  next_st.out_q[i] = cell_d[i];
                  next_st.oe_q[i]  = 1'b1;
                end
              end
              PPRSC_CELL_COMB_IO: begin
                next_st.out_q[i] = cell_d[i]; // R14
                next_st.oe_q[i]  = (st.arch == PPRSC_ARCH_SIMPLE) ? 1'b1 : st.comb_oe[i]; // R15
              end
              PPRSC_CELL_COMB_OUT: begin
                next_st.out_q[i] = cell_d[i];
                next_st.oe_q[i]  = 1'b1;
              end
              default: begin
                next_st.oe_q[i] = 1'b0; // R14
              end
            endcase
          end
        end
      end
      PPRSC_ST_HOLD: begin
        // Outputs and enables stay frozen; cell registers change only on a preload write
        if (!asleep) begin
          next_st.state = PPRSC_ST_WAKE; // R5 R6
          next_st.cnt   = 10'h000;
        end
      end
      PPRSC_ST_WAKE: begin
        next_st.cnt = st.cnt + 10'h001;
        if (st.cnt >= 10'(IN_VALID_CYC - 1)) begin
          next_st.in_block = 1'b0; // R16
        end
        if (asleep) begin
          next_st.state    = PPRSC_ST_HOLD;
          next_st.in_block = 1'b1;
        end else if (st.cnt >= 10'(OUT_VALID_CYC - 1)) begin
          next_st.state    = PPRSC_ST_RUN; // R16
          next_st.in_block = 1'b0;
        end
      end
      default: begin
        next_st.state = PPRSC_ST_CLEAR;
      end
    endcase

    // AHB-Lite address phase capture
    next_st.ph_valid = hsel && hready && htrans[1];
    if (hsel && hready) begin
      next_st.ph_write = hwrite;
      next_st.ph_addr  = haddr[7:0];
    end

    // Data phase of a previous write
    if (st.ph_valid && st.ph_write) begin
      if (st.ph_addr == ADDR_CONFIG) begin
        next_st.arch     = (hwdata[1:0] == 2'b11) ? st.arch : hwdata[1:0]; // R15
        next_st.sleep_en = hwdata[CFG_SLEEP_EN];
      end else if (st.ph_addr == ADDR_CELL_MODE) begin
        next_st.cell_mode = hwdata[15:0];
        next_st.comb_oe   = hwdata[23:16];
      end else if (st.ph_addr == ADDR_PRELOAD) begin
        if (!st.fuse && st.state != PPRSC_ST_CLEAR) begin
          for (int i = 0; i < NUM_CELLS; i++) begin
            if (hwdata[8+i]) begin
              next_st.macro_q[i] = hwdata[i]; // R10 R11
            end
          end
        end
      end else if (st.ph_addr == ADDR_SIG_LO) begin
        next_st.signature[31:0] = hwdata; // R12
      end else if (st.ph_addr == ADDR_SIG_HI) begin
        next_st.signature[63:32] = hwdata; // R12
      end else if (st.ph_addr == ADDR_VERIFY) begin
        if (!st.fuse) begin
          next_st.verify_word = hwdata;
        end
      end else if (st.ph_addr == ADDR_FUSE) begin
        if (hwdata[0]) begin
          next_st.fuse = 1'b1; // R11 R13
        end
      end
    end

    // Read data prepared during the address phase
    next_st.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (haddr[7:0] == ADDR_CONFIG) begin
        next_st.rdata = cfg_word(st);
      end else if (haddr[7:0] == ADDR_CELL_MODE) begin
        next_st.rdata = {8'h00, st.comb_oe, st.cell_mode};
      end else if (haddr[7:0] == ADDR_PRELOAD) begin
        next_st.rdata = st.fuse ? 32'h0000_0000 : {24'h000000, st.macro_q}; // R11
      end else if (haddr[7:0] == ADDR_STATUS) begin
        next_st.rdata = {28'h0000000, st.in_block, st.fuse,
                         st.state == PPRSC_ST_CLEAR, st.state == PPRSC_ST_HOLD};
      end else if (haddr[7:0] == ADDR_SIG_LO) begin
        next_st.rdata = st.signature[31:0]; // R12
      end else if (haddr[7:0] == ADDR_SIG_HI) begin
        next_st.rdata = st.signature[63:32]; // R12
      end else if (haddr[7:0] == ADDR_VERIFY) begin
        next_st.rdata = st.fuse ? 32'h0000_0000 : st.verify_word; // R11
      end else if (haddr[7:0] == ADDR_FUSE) begin
        next_st.rdata = {31'h00000000, st.fuse};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st             <= '0;
      st.state       <= PPRSC_ST_CLEAR;
      st.out_q       <= 8'hFF;
      st.in_block    <= 1'b1;
      st.arch        <= PPRSC_ARCH_REGISTERED;
      st.cell_mode   <= CELL_MODE_RESET;
      st.sleep_en    <= CONFIG_RESET[CFG_SLEEP_EN];
    end else begin
      st <= next_st;
    end
  end

  // Array inputs come from keepers so held values are seen during hold
  assign array_in     = {st.sleep_en ? 1'b0 : st.sleep_in_keep, st.in_keep};
  assign io_out       = st.out_q;
  assign io_oe        = st.oe_q;
  assign sleep_active = (st.state == PPRSC_ST_HOLD);
  assign hrdata       = st.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
endmodule // pprsc_ctrl

// ### verification/pprsc_ctrl_properties.sv
// Purpose: Port assertions for the controller
// Assumes: One clock, async active-low reset
// Notes:   Bound into every controller instance
`timescale 1ns/100ps
module pprsc_ctrl_chk
  import pprsc_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        sleep_hold_pin,
  input wire logic [7:0]  io_out,
  input wire logic [7:0]  io_oe,
  input wire logic [8:0]  array_in,
  input wire logic        sleep_active,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_clear_high: assert property ($rose(arst_n) |-> (io_out == 8'hFF)[*8])
    else $error("outputs not high after reset");
  a_hold_out: assert property (sleep_active && $past(sleep_active) |-> $stable(io_out))
    else $error("output moved in hold");
  a_hold_tri: assert property (sleep_active && $past(sleep_active) |-> $stable(io_oe))
    else $error("enable moved in hold");
  a_hold_in: assert property (sleep_active && $past(sleep_active) |-> $stable(array_in))
    else $error("input accepted in hold");
  a_hold_cause: assert property ($rose(sleep_active) |-> $past(sleep_hold_pin))
    else $error("hold without sleep pin");
  a_pin_free: assert property (sleep_active |-> !array_in[8])
    else $error("sleep pin fed array in hold");
  a_wake_quick: assert property ($fell(sleep_hold_pin) |-> ##[1:8] !sleep_active)
    else $error("wake too slow");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  c_hold: cover property ($rose(sleep_active));
  c_wake: cover property ($fell(sleep_active));
  c_read: cover property (hrdata != 32'h0);
endmodule // pprsc_ctrl_chk

bind pprsc_ctrl pprsc_ctrl_chk u_chk (.clk, .arst_n, .sleep_hold_pin, .io_out, .io_oe,
  .array_in, .sleep_active, .hreadyout, .hresp, .hrdata);

// ### verification/pprsc_sys_model.sv
// Purpose: System side driving pins and the register clock
// Assumes: Pins change just after a clk edge
// Notes:   Register clock stays low between pulses
`timescale 1ns/100ps
module pprsc_sys_model
  import pprsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] io_out,
  input  wire logic [7:0] io_oe,
  output logic            reg_clk_pin = 1'h0,
  output logic            oe_n_pin = 1'h1,
  output logic            sleep_hold_pin = 1'h0,
  output logic      [7:0] in_pin = 8'h0,
  output logic      [7:0] io_in
);
  logic [7:0] ext_io = 8'h5A;
  // Device drive wins, else the external driver
  assign io_in = (io_oe & io_out) | (~io_oe & ext_io);
  task automatic set_pins(input logic oe_n, input logic sl, input logic [7:0] i);
    @(posedge clk);
    oe_n_pin <= oe_n;
    sleep_hold_pin <= sl;
    in_pin <= i;
    ext_io <= ~i;
  endtask
  task automatic pulse();
    @(posedge clk);
    reg_clk_pin <= 1'h1;
    repeat (4) @(posedge clk);
    reg_clk_pin <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
endmodule // pprsc_sys_model

// ### verification/pld_power_reset_security_control_tb.sv
// Purpose: Self-checking bench for the controller
// Assumes: AHB-Lite master, zero wait states allowed
// Notes:   Expected values come from a small integer model
`timescale 1ns/100ps
module pld_power_reset_security_control_tb
  import pprsc_pkg::*;
;
  logic        clk = 1'h0, arst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready = 1'h1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  cell_d = 8'h0, io_out, io_oe, in_pin, io_in;
  logic [8:0]  array_in;
  logic        hreadyout, hresp, reg_clk_pin, oe_n_pin, sleep_hold_pin, sleep_active;
  int          fail_count = 0, total_checks = 0, seed = 61027, mdl_reg = 0;
  int          mdl_sig[$];
  always #5 clk = ~clk;
  pprsc_ctrl u_dut (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .reg_clk_pin, .oe_n_pin, .sleep_hold_pin,
    .in_pin, .io_in, .cell_d, .io_out, .io_oe, .array_in, .sleep_active);
  pprsc_sys_model u_sys (.clk, .io_out, .io_oe, .reg_clk_pin, .oe_n_pin,
    .sleep_hold_pin, .in_pin, .io_in);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'h1) begin
      n++;
      if (n > 40) begin
        fail_count++;
        complete_run();
      end
      @(negedge clk);
    end
    rd = hrdata;
    @(posedge clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic look(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic outchk();
    chk(32'(io_out), mdl_reg ^ 32'hFF);
  endtask
  task automatic endt(input string s);
    $display("test %0s done", s);
  endtask
  initial begin
    int i;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    look(1);
    chk(32'(io_out), 32'hFF);
    rdchk(ADDR_STATUS, 32'hA);
    i = 0;
    do begin
      ahb(1'h0, ADDR_STATUS, 32'h0);
      i++;
    end while (rd[1] !== 1'h0 && i < 60);
    chk(rd, 32'h0);
    endt("powerup");
    for (i = 0; i < 3; i++) begin
      ahb(1'h1, ADDR_CONFIG, 32'(i));
      rdchk(ADDR_CONFIG, 32'(i));
    end
    ahb(1'h1, ADDR_CELL_MODE, 32'h00FF_E4E4);
    rdchk(ADDR_CELL_MODE, 32'h00FF_E4E4);
    ahb(1'h1, ADDR_CELL_MODE, 32'h0);
    ahb(1'h1, ADDR_CONFIG, 32'h0);
    endt("modes");
    u_sys.set_pins(1'h0, 1'h0, 8'h0);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      v = $random(seed);
      cell_d <= v[7:0];
      mdl_reg = v[7:0];
      u_sys.pulse();
      look(1);
      outchk();
      chk(32'(io_oe), 32'hFF);
    end
    u_sys.set_pins(1'h1, 1'h0, 8'h0);
    look(4);
    chk(32'(io_oe), 32'h0);
    endt("registered");
    v = $random(seed);
    ahb(1'h1, ADDR_PRELOAD, {16'h0, 8'hFF, v[7:0]});
    mdl_reg = v[7:0];
    ahb(1'h1, ADDR_PRELOAD, 32'h0F00);
    mdl_reg = mdl_reg & 32'hF0;
    rdchk(ADDR_PRELOAD, mdl_reg);
    look(1);
    outchk();
    endt("preload");
    v = $random(seed);
    u_sys.set_pins(1'h1, 1'h1, v[7:0]);
    look(4);
    chk(32'(array_in), {23'h0, 1'h1, v[7:0]});
    chk(32'(sleep_active), 32'h0);
    u_sys.set_pins(1'h1, 1'h0, v[7:0]);
    ahb(1'h1, ADDR_CONFIG, 32'h4);
    u_sys.set_pins(1'h1, 1'h1, v[7:0]);
    look(5);
    chk(32'(sleep_active), 32'h1);
    rdchk(ADDR_STATUS, 32'h9);
    @(posedge clk);
    cell_d <= ~cell_d;
    u_sys.set_pins(1'h0, 1'h1, ~v[7:0]);
    u_sys.pulse();
    look(1);
    outchk();
    chk(32'(io_oe), 32'h0);
    chk(32'(array_in), {24'h0, v[7:0]});
    u_sys.set_pins(1'h0, 1'h0, ~v[7:0]);
    look(7);
    chk(32'(sleep_active), 32'h0);
    chk(32'(io_oe), 32'hFF);
    chk(32'(array_in), {24'h0, ~v[7:0]});
    endt("sleep");
    for (i = 0; i < 2; i++) begin
      v = $random(seed);
      mdl_sig.push_back(v);
      ahb(1'h1, i ? ADDR_SIG_HI : ADDR_SIG_LO, v);
    end
    ahb(1'h1, ADDR_FUSE, 32'h1);
    rdchk(ADDR_STATUS, 32'h4);
    rdchk(ADDR_VERIFY, 32'h0);
    ahb(1'h1, ADDR_PRELOAD, 32'hFF00);
    rdchk(ADDR_PRELOAD, 32'h0);
    look(1);
    outchk();
    rdchk(ADDR_SIG_LO, mdl_sig[0]);
    rdchk(ADDR_SIG_HI, mdl_sig[1]);
    rdchk(8'h20, 32'h0);
    endt("fuse");
    @(posedge clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    look(1);
    chk(32'(io_out), 32'hFF);
    rdchk(ADDR_STATUS, 32'hA);
    endt("rereset");
    complete_run();
  end
endmodule // pld_power_reset_security_control_tb
